// >>> design/dsc_consts.svh
// Purpose: constants of the disk serial command control block
// Assumes: 32-bit APB with byte addresses, cable pins active low
// Notes:   widths of the state struct live in the package
`ifndef DSC_CONSTS_SVH
`define DSC_CONSTS_SVH
// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define DSC_OFF_CTRL   8'h00
`define DSC_OFF_STAT   8'h04
`define DSC_OFF_CMD    8'h08
`define DSC_OFF_POS    8'h0C
`define DSC_OFF_RATE   8'h10
`define DSC_OFF_VEND   8'h14
`define DSC_A_PAGE     7:6
`define DSC_A_WORD     5:2
`define DSC_CFG_PAGE   2'h1
// ----------------------------------------------------------------
// control register fields and reset values
// ----------------------------------------------------------------
`define DSC_CF_ADDR    2:0
`define DSC_CF_HEADS   7:4
`define DSC_CF_MAP     8
`define DSC_CF_WPROT   9
`define DSC_CF_W       9:0
`define DSC_CTRL_RST   10'h081
`define DSC_STAT_RST   16'h0100
// ----------------------------------------------------------------
// standard status bits
// ----------------------------------------------------------------
`define DSC_ST_STATE   15:12
`define DSC_ST_WPROT   12
`define DSC_ST_MSTOP   9
`define DSC_ST_POR     8
`define DSC_ST_PAR     7
`define DSC_ST_INV     5
`define DSC_ST_WOFF    3
`define DSC_ST_WFLT    1
`define DSC_ATTN_MASK  16'h0FFF
// ----------------------------------------------------------------
// command word
// ----------------------------------------------------------------
`define DSC_FN_SEEK    4'h0
`define DSC_FN_RECAL   4'h1
`define DSC_FN_STAT    4'h2
`define DSC_FN_CFG     4'h3
`define DSC_FN_CTL     4'h5
`define DSC_FN_OFFS    4'h7
`define DSC_MOD_STD    4'h0
`define DSC_MOD_STOP   4'h2
`define DSC_MOD_START  4'h3
`define DSC_MOD_RSVD   3
`define DSC_SUB_GEN    8'h00
`define DSC_SUB_MAP    8'h01
`define DSC_SUB_RATE   8'h08
`define DSC_MAP_YES    16'h8000
`define DSC_LAST_BIT   5'h10
// ----------------------------------------------------------------
// synchronised pin vector
// ----------------------------------------------------------------
`define DSC_PIN_W      12
`define DSC_PIN_IDLE   12'hFFF
`define DSC_PIN_JMP    11
`define DSC_PIN_HEAD   10:7
`define DSC_PIN_WG     6
`define DSC_PIN_RG     5
`define DSC_PIN_REQ    4
`define DSC_PIN_CMD    3
`define DSC_PIN_DSEL   2:0
`define DSC_BOOT_STRAP 2'h2
`define DSC_BOOT_DONE  2'h3
`endif

// >>> design/dsc_ctrl.sv
// Purpose: drive-side control inputs: select, gates, serial command word
// Assumes: cable pins active low, autostart jumper active high, all far slower than pclk
// Notes:   registers over APB with one wait state per access
`include "dsc_consts.svh"
module dsc_ctrl
#(
  parameter int EXEC_CYCLES = 64,
  parameter int PLO_CYCLES  = 96
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire dsc_pkg::dsc_head_t head_sel_n,
  input  wire logic              write_gate_n,
  input  wire logic              read_gate_n,
  input  wire logic              xfer_req_n,
  input  wire logic              cmd_data_n,
  input  wire logic [2:0]        drive_sel_n,
  input  wire logic              motor_autostart_jumper,
  output logic                   xfer_ack_n,
  output logic                   cfg_status_data_n,
  output logic                   attention_n,
  output logic                   cmd_complete_n,
  output logic                   drive_selected_n,
  output logic                   write_enable,
  output logic                   read_enable,
  output logic                   write_splice,
  output logic                   plo_field,
  output logic                   motor_run
);
  import dsc_pkg::*;

  localparam logic [15:0] EXEC_LEN = 16'(EXEC_CYCLES);
  localparam logic [15:0] PLO_LEN  = 16'(PLO_CYCLES);

  dsc_state_s                s;
  dsc_state_s                n;
  logic [`DSC_PIN_W-1:0]     pin_q;
  logic [3:0]                head;
  logic [2:0]                dsel;
  logic                      sel;
  logic                      wg;
  logic                      rg;
  logic                      req;
  logic                      cbit;
  logic                      jumper;
  logic                      rx_done;
  logic                      par_good;
  logic                      bad_cmd;
  logic                      has_rsp;
  logic                      clr;
  logic                      rise;
  logic [3:0]                fn;
  logic [3:0]                md;
  logic [7:0]                sub;
  logic [15:0]               rsp;
  logic [15:0]               evt;

  // odd parity bit for a 16-bit word
  function automatic logic odd_par(input logic [15:0] w);
    odd_par = ~^w;
  endfunction : odd_par

  // ----------------------------------------------------------------
  // pin capture
  // ----------------------------------------------------------------
  dsc_sync #(.W(`DSC_PIN_W), .RST(`DSC_PIN_IDLE)) u_sync
  (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({motor_autostart_jumper, head_sel_n, write_gate_n, read_gate_n,
               xfer_req_n, cmd_data_n, drive_sel_n}),
    .q       (pin_q)
  );

  assign head     = ~pin_q[`DSC_PIN_HEAD];
  assign dsel     = ~pin_q[`DSC_PIN_DSEL];
  assign sel      = (dsel != 3'h0) && (dsel == s.ctrl[`DSC_CF_ADDR]);
  assign wg       = sel && !pin_q[`DSC_PIN_WG];
  assign rg       = sel && !pin_q[`DSC_PIN_RG];
  assign req      = sel && !pin_q[`DSC_PIN_REQ];
  assign cbit     = !pin_q[`DSC_PIN_CMD];
  assign jumper   = pin_q[`DSC_PIN_JMP];
  assign rx_done  = (s.st == st_rx) && s.ack && !req && (s.bitn == `DSC_LAST_BIT);
  assign par_good = odd_par(s.sh[16:1]) == s.sh[0];
  assign fn       = s.sh[16:13];
  assign md       = s.sh[12:9];
  assign sub      = s.sh[8:1];
  assign clr      = rx_done && par_good && (fn == `DSC_FN_CTL) && (md == `DSC_MOD_STD);
  assign rise     = |(evt & (clr ? 16'hFFFF : ~s.stat) & `DSC_ATTN_MASK);

  // ----------------------------------------------------------------
  // command decode and response word
  // ----------------------------------------------------------------
  always_comb
  begin
    bad_cmd = 1'b0;
    has_rsp = 1'b0;
    rsp     = 16'h0000;
    case (fn)
      `DSC_FN_SEEK, `DSC_FN_RECAL: bad_cmd = 1'b0;
      `DSC_FN_OFFS: bad_cmd = md[`DSC_MOD_RSVD];
      `DSC_FN_STAT:
      begin
        has_rsp = 1'b1;
        bad_cmd = md[`DSC_MOD_RSVD];
        rsp     = (md == `DSC_MOD_STD) ? s.stat : s.vend;
      end
      `DSC_FN_CFG:
      begin
        has_rsp = 1'b1;
        if (md != `DSC_MOD_STD)
          rsp = s.cfg[md];
        else if (sub == `DSC_SUB_GEN)
          rsp = s.cfg[md];
        else if (sub == `DSC_SUB_MAP)
          rsp = s.ctrl[`DSC_CF_MAP] ? `DSC_MAP_YES : 16'h0000;
        else if (sub == `DSC_SUB_RATE)
          rsp = s.rate;
        else
          bad_cmd = 1'b1;
      end
      `DSC_FN_CTL:
        bad_cmd = !((md == `DSC_MOD_STD) || (md == `DSC_MOD_STOP) || (md == `DSC_MOD_START));
      default: bad_cmd = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // fault and change events
  // ----------------------------------------------------------------
  always_comb
  begin
    evt = 16'h0000;
    // busy counts as writing before command complete
    evt[`DSC_ST_WFLT]  = wg && ((head >= s.ctrl[`DSC_CF_HEADS]) || (s.st == st_exec) || rg
                                || s.ctrl[`DSC_CF_WPROT] || !s.motor);
    evt[`DSC_ST_WOFF]  = wg && (s.offs != 4'h0);
    evt[`DSC_ST_PAR]   = rx_done && !par_good;
    evt[`DSC_ST_INV]   = rx_done && par_good && bad_cmd;
    evt[`DSC_ST_MSTOP] = (s.boot == `DSC_BOOT_DONE) && !s.motor;
    evt[`DSC_ST_WPROT] = s.ctrl[`DSC_CF_WPROT];
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    n      = s;
    n.wg_d = wg;
    // strap read only once the synchroniser holds a real pin level
    if (s.boot != `DSC_BOOT_DONE)
      n.boot = s.boot + 2'h1;
    if ((s.boot == `DSC_BOOT_STRAP) && jumper)
      n.motor = 1'b1;

    n.stat = (clr ? 16'h0000 : s.stat) | evt;
    n.stat[`DSC_ST_STATE] = evt[`DSC_ST_STATE];
    if (rise)
      n.attn = 1'b1;
    else if (clr)
      n.attn = 1'b0;

    case (s.st)
      st_idle, st_rx:
      begin
        if (req && !s.ack)
        begin
          n.ack = 1'b1;
          n.sh  = {s.sh[15:0], cbit};
          n.st  = st_rx;
        end
        else if (s.ack && !req)
        begin
          n.ack  = 1'b0;
          n.bitn = s.bitn + 5'h01;
          if (rx_done)
          begin
            n.bitn = 5'h00;
            n.cmd  = s.sh[16:1];
            n.st   = st_idle;
            if (par_good && !bad_cmd)
            begin
              n.st  = st_exec;
              n.cnt = EXEC_LEN;
              case (fn)
                `DSC_FN_SEEK:
                begin
                  n.cyl  = s.sh[12:1];
                  n.offs = 4'h0;
                end
                `DSC_FN_RECAL:
                begin
                  n.cyl  = 12'h000;
                  n.offs = 4'h0;
                end
                `DSC_FN_OFFS: n.offs = md;
                `DSC_FN_CTL:
                begin
                  if (!jumper && (md == `DSC_MOD_STOP))
                    n.motor = 1'b0;
                  if (!jumper && (md == `DSC_MOD_START))
                    n.motor = 1'b1;
                end
                default: n.cnt = EXEC_LEN;
              endcase
            end
          end
        end
      end
      st_exec:
      begin
        if (s.cnt <= 16'h0001)
        begin
          n.cnt = 16'h0000;
          n.st  = has_rsp ? st_tx : st_idle;
          if (has_rsp)
            n.sh = {rsp, odd_par(rsp)};
        end
        else
          n.cnt = s.cnt - 16'h0001;
      end
      st_tx:
      begin
        // bit already on the line when the request comes
        if (req && !s.ack)
          n.ack = 1'b1;
        else if (s.ack && !req)
        begin
          n.ack = 1'b0;
          n.sh  = {s.sh[15:0], 1'b0};
          n.bitn = s.bitn + 5'h01;
          if (s.bitn == `DSC_LAST_BIT)
          begin
            n.bitn = 5'h00;
            n.st   = st_idle;
          end
        end
      end
      default: n.st = st_idle;
    endcase

    if (!wg)
      n.plo = 16'h0000;
    else if (!s.wg_d)
      n.plo = PLO_LEN;
    else if (s.plo != 16'h0000)
      n.plo = s.plo - 16'h0001;

    // ----------------------------------------------------------------
    // apb slave, one wait state
    // ----------------------------------------------------------------
    n.pready  = psel && penable && !s.pready;
    n.pslverr = 1'b0;
    n.prdata  = 32'h0000_0000;
    if (psel && penable && !s.pready)
    begin
      if (paddr[`DSC_A_PAGE] == `DSC_CFG_PAGE)
      begin
        n.prdata = {16'h0000, s.cfg[paddr[`DSC_A_WORD]]};
        if (pwrite)
          n.cfg[paddr[`DSC_A_WORD]] = pwdata[15:0];
      end
      else
      begin
        case ({paddr[7:2], 2'b00})
          `DSC_OFF_CTRL:
          begin
            n.prdata = {22'h0, s.ctrl};
            if (pwrite)
              n.ctrl = pwdata[`DSC_CF_W];
          end
          `DSC_OFF_STAT: n.prdata = {15'h0, s.attn, s.stat};
          `DSC_OFF_CMD:  n.prdata = {13'h0, s.motor, s.st, s.cmd};
          `DSC_OFF_POS:  n.prdata = {16'h0, s.offs, s.cyl};
          `DSC_OFF_RATE:
          begin
            n.prdata = {16'h0, s.rate};
            if (pwrite)
              n.rate = pwdata[15:0];
          end
          `DSC_OFF_VEND:
          begin
            n.prdata = {16'h0, s.vend};
            if (pwrite)
              n.vend = pwdata[15:0];
          end
          default: n.pslverr = 1'b1;
        endcase
      end
    end

    // ----------------------------------------------------------------
    // registered pin and side outputs
    // ----------------------------------------------------------------
    n.o_ack_n  = !(n.ack && sel);
    n.o_csd_n  = !((n.st == st_tx) && n.sh[16] && sel);
    n.o_attn_n = !(n.attn && sel);
    n.o_dsel_n = !sel;
    n.o_cc_n   = (n.st == st_exec) || (s.boot != `DSC_BOOT_DONE);
    n.o_wr     = wg && !evt[`DSC_ST_WFLT] && !evt[`DSC_ST_WOFF];
    n.o_rd     = rg && !wg && (s.st != st_exec) && s.motor;
    n.o_splice = wg && !s.wg_d;
    n.o_plo    = n.plo != 16'h0000;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s          <= '0;
      s.stat     <= `DSC_STAT_RST;
      s.attn     <= 1'b1;
      s.ctrl     <= `DSC_CTRL_RST;
      s.o_ack_n  <= 1'b1;
      s.o_csd_n  <= 1'b1;
      s.o_attn_n <= 1'b1;
      s.o_dsel_n <= 1'b1;
      s.o_cc_n   <= 1'b1;
    end
    else
      s <= n;
  end

  assign prdata            = s.prdata;
  assign pready            = s.pready;
  assign pslverr           = s.pslverr;
  assign xfer_ack_n        = s.o_ack_n;
  assign cfg_status_data_n = s.o_csd_n;
  assign attention_n       = s.o_attn_n;
  assign cmd_complete_n    = s.o_cc_n;
  assign drive_selected_n  = s.o_dsel_n;
  assign write_enable      = s.o_wr;
  assign read_enable       = s.o_rd;
  assign write_splice      = s.o_splice;
  assign plo_field         = s.o_plo;
  assign motor_run         = s.motor;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_req_new;
    req && !s.ack && (s.st != st_exec);
  endsequence
  sequence s_tx_bit_done;
    (s.st == st_tx) && s.ack && !req;
  endsequence
  sequence s_wg_start;
    wg && !s.wg_d;
  endsequence
  sequence s_good_cmd(logic [3:0] f);
    rx_done && par_good && (fn == f);
  endsequence

  a_ack_follows_req: assert property (s_req_new |=> s.ack)
    else $error("ack did not follow a new request");
  a_tx_odd_parity: assert property ((s.st != st_tx) ##1 (s.st == st_tx) |-> ^s.sh)
    else $error("response word has even parity");
  a_tx_msb_first: assert property (s_tx_bit_done |=> s.sh[16] == $past(s.sh[15]))
    else $error("response not shifted msb first");
  a_parity_fault: assert property (rx_done && !par_good |=> s.stat[`DSC_ST_PAR] && (s.st == st_idle))
    else $error("bad parity not flagged");
  a_seek_loads: assert property (s_good_cmd(`DSC_FN_SEEK) |=> (s.cyl == s.cmd[11:0]) && (s.offs == 4'h0)
                                 ##1 (s.st == st_exec))
    else $error("seek did not load cylinder");
  a_recal_zero: assert property (s_good_cmd(`DSC_FN_RECAL) |=> (s.cyl == 12'h000) && (s.offs == 4'h0))
    else $error("recalibrate did not reach zero");
  a_invalid_cmd: assert property (rx_done && par_good && bad_cmd |=> s.stat[`DSC_ST_INV] && (s.st == st_idle))
    else $error("invalid command not flagged");
  a_busy_inhibit: assert property ((s.st == st_exec) |=> !write_enable && !read_enable)
    else $error("read or write during execution");
  a_head_fault: assert property (wg && (head >= s.ctrl[`DSC_CF_HEADS]) |=> s.stat[`DSC_ST_WFLT] && !write_enable)
    else $error("missing head write fault");
  a_splice_pulse: assert property (s_wg_start |=> write_splice ##1 !write_splice)
    else $error("splice pulse wrong");
  a_attn_on_fault: assert property (rise |=> s.attn ##1 (attention_n == !sel))
    else $error("attention not raised");
  a_attn_cause: assert property ($rose(s.attn) |-> $past(rise))
    else $error("attention without a fault bit");
  a_motor_stop: assert property (rx_done && par_good && (fn == `DSC_FN_CTL) && !jumper
                                 && (md == `DSC_MOD_STOP) |=> !s.motor)
    else $error("motor not stopped");
endmodule : dsc_ctrl

// >>> design/dsc_pkg.sv
// Purpose: shared types of the disk serial command control block
// Assumes: field widths match the consts header
// Notes:   the whole control state is one packed struct
package dsc_pkg;
  typedef logic [3:0] dsc_head_t;
  typedef enum logic [1:0] {st_idle, st_rx, st_exec, st_tx} dsc_state_e;
  typedef struct packed {
    dsc_state_e        st;
    logic              ack;
    logic [4:0]        bitn;
    logic [16:0]       sh;
    logic [15:0]       cmd;
    logic [15:0]       cnt;
    logic [15:0]       plo;
    logic              wg_d;
    logic [1:0]        boot;
    logic              motor;
    logic [15:0]       stat;
    logic              attn;
    logic [11:0]       cyl;
    logic [3:0]        offs;
    logic [9:0]        ctrl;
    logic [15:0]       rate;
    logic [15:0]       vend;
    logic [15:0][15:0] cfg;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
    logic              o_ack_n;
    logic              o_csd_n;
    logic              o_attn_n;
    logic              o_dsel_n;
    logic              o_cc_n;
    logic              o_wr;
    logic              o_rd;
    logic              o_splice;
    logic              o_plo;
  } dsc_state_s;
endpackage : dsc_pkg

// >>> design/dsc_sync.sv
// Purpose: two-flop synchroniser for cable pins
// Assumes: reset value is the idle level of the pins
// Notes:   first stage feeds only the second stage
module dsc_sync
#(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
)
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta <= RST;
      q    <= RST;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : dsc_sync

// >>> tb/dsc_host.sv
// Purpose: host controller model on the command cable
// Assumes: pins active low, one bit per req/ack handshake
// Notes:   waits are bounded; a lost handshake is counted in lost
module dsc_host
(
  input  wire logic pclk,
  input  wire logic xfer_ack_n,
  input  wire logic cfg_status_data_n,
  output logic      xfer_req_n,
  output logic      cmd_data_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int lost = 0;
  initial
  begin
    xfer_req_n = 1'b1;
    cmd_data_n = 1'b1;
  end
  // --------------------------------------------------------------
  // one handshake, bit set one edge before req
  // --------------------------------------------------------------
  task automatic xfer_bit(input logic b, output logic r);
    int n;
    @(posedge pclk) cmd_data_n <= ~b;
    @(posedge pclk) xfer_req_n <= 1'b0;
    for (n = 0; n < 40 && xfer_ack_n !== 1'b0; n++) @(posedge pclk);
    lost += (n == 40);
    r = ~cfg_status_data_n;
    xfer_req_n <= 1'b1;
    for (n = 0; n < 40 && xfer_ack_n !== 1'b1; n++) @(posedge pclk);
    lost += (n == 40);
  endtask : xfer_bit
  // flip spoils parity on purpose for the refusal case
  task automatic send_cmd(input logic [15:0] w, input logic flip);
    logic [16:0] f;
    logic        r;
    f = {w, ~^w ^ flip};
    for (int i = 16; i >= 0; i--) xfer_bit(f[i], r);
    cmd_data_n <= 1'b1;
  endtask : send_cmd
  task automatic get_resp(output logic [16:0] d);
    logic r;
    for (int i = 16; i >= 0; i--)
    begin
      xfer_bit(1'b0, r);
      d[i] = r;
    end
  endtask : get_resp
  // req held low for a while; reports any ack seen
  task automatic probe(output logic seen);
    seen = 1'b0;
    @(posedge pclk) xfer_req_n <= 1'b0;
    repeat (10) @(posedge pclk) seen |= ~xfer_ack_n;
    xfer_req_n <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask : probe
endmodule : dsc_host

// >>> tb/tb_top.sv
// Purpose: self-checking bench for the serial command control block
// Assumes: host model on the cable, APB master in this module
// Notes:   short exec and PLO counts keep the run brief
`include "dsc_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dsc_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, ack_n, csd_n, attn_n, cc_n, dsel_n, wen, ren, spl, plo, mrun;
  logic        req_n, cmd_n, e, seen, wg_n = 1'b1, rg_n = 1'b1, jmp = 1'b1;
  dsc_head_t   head_sel_n = 4'hF;
  logic [2:0]  drive_sel_n = 3'b110;
  logic [16:0] resp;
  int          failures = 0, checks = 0, n, pl;
  // command in the top half, expected answer or position below
  logic [31:0] rows [10] = '{32'h5000_0000, 32'h2000_0000, 32'h0123_0123, 32'h7200_2123, 32'h1000_0000,
                             32'h3008_3A98, 32'h3001_8000, 32'h2100_5A5A, 32'h3200_1234, 32'h3000_00C3};
  dsc_ctrl #(.EXEC_CYCLES(4), .PLO_CYCLES(4)) dsc_ctrl_i
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .head_sel_n(head_sel_n), .write_gate_n(wg_n), .read_gate_n(rg_n), .xfer_req_n(req_n),
    .cmd_data_n(cmd_n), .drive_sel_n(drive_sel_n), .motor_autostart_jumper(jmp),
    .xfer_ack_n(ack_n), .cfg_status_data_n(csd_n), .attention_n(attn_n), .cmd_complete_n(cc_n),
    .drive_selected_n(dsel_n), .write_enable(wen), .read_enable(ren), .write_splice(spl),
    .plo_field(plo), .motor_run(mrun)
  );
  dsc_host host_i
  (
    .pclk(pclk), .xfer_ack_n(ack_n), .cfg_status_data_n(csd_n), .xfer_req_n(req_n), .cmd_data_n(cmd_n)
  );
  initial
  begin
    forever #4 pclk = ~pclk;
  end
  // --------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++k < 20);
    failures += (k == 20);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : reg_chk
  // waits for the drive to report completion
  task automatic run_cmd(input logic [15:0] w, input logic flip);
    host_i.send_cmd(w, flip);
    repeat (2) @(posedge pclk);
    for (n = 0; n < 60 && cc_n !== 1'b0; n++) @(posedge pclk);
    failures += (n == 60);
  endtask : run_cmd
  task automatic print_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  initial
  begin
    repeat (30000) @(posedge pclk);
    failures++;
    print_verdict();
  end
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    apb(1'b1, `DSC_OFF_CTRL, 32'h181);
    apb(1'b1, `DSC_OFF_RATE, 32'h3A98);
    apb(1'b1, `DSC_OFF_VEND, 32'h5A5A);
    apb(1'b1, 8'h48, 32'h1234);
    apb(1'b1, 8'h40, 32'hC3);
    foreach (rows[i])
    begin
      run_cmd(rows[i][31:16], 1'b0);
      if (rows[i][31:29] == 3'b001)
      begin
        host_i.get_resp(resp);
        chk({16'h0, resp[16:1]}, {16'h0, rows[i][15:0]});
        chk({31'h0, ^resp}, 32'h1);
      end
      else
        reg_chk(`DSC_OFF_POS, {16'h0, rows[i][15:0]});
      $display("row %0d done", i);
    end
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, e}, 32'h1);
    @(posedge pclk) wg_n <= 1'b0;
    seen = 1'b0;
    pl   = 0;
    repeat (8) @(posedge pclk)
    begin
      seen |= spl;
      pl   += plo;
    end
    chk({31'h0, seen}, 32'h1);
    chk(pl, 32'd4);
    chk({31'h0, plo}, 32'h0);
    chk({31'h0, wen}, 32'h1);
    wg_n <= 1'b1;
    head_sel_n <= ~4'd8;
    repeat (6) @(posedge pclk);
    wg_n <= 1'b0;
    repeat (8) @(posedge pclk);
    chk({31'h0, wen}, 32'h0);
    {wg_n, head_sel_n} <= 5'h1F;
    reg_chk(`DSC_OFF_STAT, 32'h10002);
    $display("write gate test done");
    rg_n <= 1'b0;
    repeat (5) @(posedge pclk);
    chk({31'h0, ren}, 32'h1);
    run_cmd(16'h5000, 1'b0);
    rg_n <= 1'b1;
    run_cmd(16'h4000, 1'b0);
    reg_chk(`DSC_OFF_STAT, 32'h10020);
    chk({31'h0, attn_n}, 32'h0);
    run_cmd(16'h5000, 1'b1);
    reg_chk(`DSC_OFF_STAT, 32'h100A0);
    run_cmd(16'h5000, 1'b0);
    apb(1'b1, `DSC_OFF_CTRL, 32'h381);
    reg_chk(`DSC_OFF_STAT, 32'h01000);
    chk({31'h0, attn_n}, 32'h1);
    apb(1'b1, `DSC_OFF_CTRL, 32'h181);
    $display("status test done");
    drive_sel_n <= 3'b101;
    repeat (4) @(posedge pclk);
    chk({31'h0, dsel_n}, 32'h1);
    host_i.probe(seen);
    chk({31'h0, seen}, 32'h0);
    drive_sel_n <= 3'b110;
    $display("select test done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({30'h0, cc_n, ack_n}, 32'h3);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    reg_chk(`DSC_OFF_CTRL, 32'h081);
    reg_chk(`DSC_OFF_STAT, 32'h10100);
    chk({31'h0, mrun}, 32'h1);
    {presetn, jmp} <= 2'b00;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    chk({31'h0, mrun}, 32'h0);
    run_cmd(16'h5300, 1'b0);
    chk({31'h0, mrun}, 32'h1);
    run_cmd(16'h5200, 1'b0);
    chk({31'h0, mrun}, 32'h0);
    chk(host_i.lost, 32'h0);
    $display("reset test done");
    print_verdict();
  end
endmodule : tb_top
